/* include/eso_pkg.sv */
// Package holding types and constants for the byte-order and reservation block
package eso_pkg;

  localparam logic       ORDER_LITTLE   = 1'h0;
  localparam logic       ORDER_BIG      = 1'h1;

  localparam int         AV_ADDR_W      = 4;
  localparam int         AV_DATA_W      = 32;
  localparam int         GPR_IDX_W      = 5;
  localparam int         GPR_DATA_W     = 32;

  localparam logic [3:0] OFS_CONTROL    = 4'h0;
  localparam logic [3:0] OFS_STATUS     = 4'h4;
  localparam logic [3:0] OFS_SC_COUNT   = 4'h8;

  localparam int         CTL_FLIP_BIT   = 0;
  localparam int         STA_MEM_BIT    = 0;
  localparam int         STA_CPU_BIT    = 1;
  localparam int         STA_FLIP_BIT   = 2;
  localparam int         STA_RSV_BIT    = 3;
  localparam int         STA_USER_BIT   = 4;
  localparam int         STA_PEND_BIT   = 5;
  localparam int         STA_W          = 6;
  localparam int         SC_CNT_W       = 16;

  localparam logic       RST_FLIP       = 1'h0;
  localparam logic       RST_MEM_ORDER  = 1'h0;
  localparam logic       RST_WAITREQ    = 1'h1;

  typedef enum logic [4:0] {
    ESO_OP_NONE  = 5'h01,
    ESO_OP_LL    = 5'h02,
    ESO_OP_SC    = 5'h04,
    ESO_OP_ERET  = 5'h08,
    ESO_OP_OTHER = 5'h10
  } eso_op_t;

  typedef enum logic [1:0] {
    ESO_RSV_IDLE = 2'h1,
    ESO_RSV_HELD = 2'h2
  } eso_rsv_t;

  typedef struct packed {
    logic                  valid;
    eso_op_t               op;
    logic                  wr_now;
    logic [GPR_IDX_W-1:0]  now_idx;
    logic [GPR_DATA_W-1:0] now_data;
    logic                  wr_late;
    logic [GPR_IDX_W-1:0]  late_idx;
    logic [GPR_DATA_W-1:0] late_data;
  } eso_step_t;

  typedef struct packed {
    logic                  valid;
    logic [GPR_IDX_W-1:0]  idx;
    logic [GPR_DATA_W-1:0] data;
  } eso_wb_t;

  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [AV_ADDR_W-1:0]  address;
    logic [3:0]            byteenable;
    logic [AV_DATA_W-1:0]  writedata;
  } eso_av_req_t;

endpackage

/* verilog/eso_avs.sv */
// Avalon-MM slave with waitrequest holding the control register
`timescale 1ns/10ps
`default_nettype none
module eso_avs
  import eso_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire eso_av_req_t           av_req,
  input  wire logic [STA_W-1:0]      status_in,
  input  wire logic [SC_CNT_W-1:0]   sc_count_in,
  output logic                       waitrequest_r,
  output logic [AV_DATA_W-1:0]       readdata_r,
  output logic                       order_flip_bit_r
);

  logic                 waitrequest_nxt;
  logic [AV_DATA_W-1:0] readdata_nxt;
  logic                 order_flip_bit_nxt;
  logic                 req;

  always_comb begin
    req                = av_req.read | av_req.write;
    waitrequest_nxt    = waitrequest_r;
    readdata_nxt       = readdata_r;
    order_flip_bit_nxt = order_flip_bit_r;
    if (req && waitrequest_r) begin
      // First cycle of a request: latch read data, release wait next cycle
      waitrequest_nxt = 1'h0;
      readdata_nxt    = '0;
      unique case (av_req.address)
        OFS_CONTROL:  readdata_nxt[CTL_FLIP_BIT] = order_flip_bit_r;
        OFS_STATUS:   readdata_nxt[STA_W-1:0] = status_in;
        OFS_SC_COUNT: readdata_nxt[SC_CNT_W-1:0] = sc_count_in;
        default:      readdata_nxt = '0;
      endcase
    end else if (!waitrequest_r) begin
      // Completion edge: the write takes effect here
      waitrequest_nxt = 1'h1;
      if (av_req.write && av_req.address == OFS_CONTROL && av_req.byteenable[0]) begin
        order_flip_bit_nxt = av_req.writedata[CTL_FLIP_BIT];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      waitrequest_r    <= RST_WAITREQ;
      readdata_r       <= '0;
      order_flip_bit_r <= RST_FLIP;
    end else if (ce) begin
      waitrequest_r    <= waitrequest_nxt;
      readdata_r       <= readdata_nxt;
      order_flip_bit_r <= order_flip_bit_nxt;
    end
  end

endmodule
`default_nettype wire

/* verilog/eso_top.sv */
// Load/store byte-order select, reservation flag and instruction-time sequencing
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE_01 - Byte order is one bit: 0 little-endian, 1 big-endian.
// RULE_02 - Load/store byte order is memory order XOR user flip.
// RULE_03 - User flip is active only with status flip bit set in User mode.
// RULE_04 - Linked load sets reservation; conditional store tests it, then clears it.
// RULE_05 - Activity breaking atomicity of a later store clears the reservation.
// RULE_06 - Exception return clears the reservation.
// RULE_07 - Undeferred instruction effects appear in that instruction's own time.
// RULE_08 - Effects deferred one instruction appear with the next instruction's effects.
// RULE_09 - Effects within one instruction apply in listed step order.
// RULE_10 - Sections of different instructions in one time have no guaranteed order.
// RULE_11 - Memory byte order is fixed at chip reset, 0 little, 1 big.
// RULE_12 - Reservation is cleared at reset.
module eso_top
  import eso_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  memory_byte_order,
  input  wire logic                  user_mode,
  input  wire logic                  atomic_break,
  input  wire eso_step_t             step,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [AV_ADDR_W-1:0]  avs_address,
  input  wire logic [3:0]            avs_byteenable,
  input  wire logic [AV_DATA_W-1:0]  avs_writedata,
  output logic                       avs_waitrequest,
  output logic [AV_DATA_W-1:0]       avs_readdata,
  output logic                       cpu_byte_order_r,
  output logic                       user_order_flip_r,
  output logic                       reservation_flag_r,
  output logic                       sc_done_r,
  output logic                       sc_success_r,
  output eso_wb_t                    wb_now_r,
  output eso_wb_t                    wb_late_r
);

  function automatic logic op_is(input eso_op_t op, input eso_op_t code);
    op_is = (op == code);
  endfunction

  // Bus side
  eso_av_req_t          av_req;
  logic [STA_W-1:0]     status_word;
  logic                 order_flip_bit_r;
  logic [SC_CNT_W-1:0]  sc_count_r;
  logic [SC_CNT_W-1:0]  sc_count_nxt;

  // Reset-time memory order capture
  logic                 mem_order_r;
  logic                 mem_order_nxt;
  logic                 strap_done_r;
  logic                 strap_done_nxt;

  // Byte order outputs
  logic                 cpu_byte_order_nxt;
  logic                 user_order_flip_nxt;

  // Reservation
  eso_rsv_t             rsv_r;
  eso_rsv_t             rsv_nxt;
  logic                 reservation_flag_nxt;
  logic                 sc_done_nxt;
  logic                 sc_success_nxt;

  // Instruction-time sequencing
  eso_wb_t              pend_r;
  eso_wb_t              pend_nxt;
  eso_wb_t              wb_now_nxt;
  eso_wb_t              wb_late_nxt;

  always_comb begin
    av_req.read       = avs_read;
    av_req.write      = avs_write;
    av_req.address    = avs_address;
    av_req.byteenable = avs_byteenable;
    av_req.writedata  = avs_writedata;
  end

  always_comb begin
    status_word               = '0;
    status_word[STA_MEM_BIT]  = mem_order_r;
    status_word[STA_CPU_BIT]  = cpu_byte_order_r;
    status_word[STA_FLIP_BIT] = user_order_flip_r;
    status_word[STA_RSV_BIT]  = reservation_flag_r;
    status_word[STA_USER_BIT] = user_mode;
    status_word[STA_PEND_BIT] = pend_r.valid;
  end

  eso_avs u_avs (
    .mclk             (mclk),
    .rst              (rst),
    .ce               (ce),
    .av_req           (av_req),
    .status_in        (status_word),
    .sc_count_in      (sc_count_r),
    .waitrequest_r    (avs_waitrequest),
    .readdata_r       (avs_readdata),
    .order_flip_bit_r (order_flip_bit_r)
  );

  // Memory byte order: caught once on the first enabled edge after reset release
  always_comb begin
    mem_order_nxt  = mem_order_r;
    strap_done_nxt = strap_done_r;
    if (!strap_done_r) begin
      mem_order_nxt  = memory_byte_order; // RULE_11
      strap_done_nxt = 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_order_r  <= RST_MEM_ORDER;
      strap_done_r <= 1'h0;
    end else if (ce) begin
      mem_order_r  <= mem_order_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  // Effective byte order for loads and stores
  always_comb begin
    user_order_flip_nxt = order_flip_bit_r & user_mode; // RULE_03
    cpu_byte_order_nxt  = mem_order_r ^ user_order_flip_nxt; // RULE_01 RULE_02
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      user_order_flip_r <= 1'h0;
      cpu_byte_order_r  <= ORDER_LITTLE;
    end else if (ce) begin
      user_order_flip_r <= user_order_flip_nxt;
      cpu_byte_order_r  <= cpu_byte_order_nxt;
    end
  end

  // Reservation state; a linked load wins over a same-cycle atomic break
  always_comb begin
    rsv_nxt        = rsv_r;
    sc_done_nxt    = 1'h0;
    sc_success_nxt = 1'h0;
    sc_count_nxt   = sc_count_r;
    if (atomic_break) begin
      rsv_nxt = ESO_RSV_IDLE; // RULE_05
    end
    if (step.valid) begin
      unique case (1'h1)
        op_is(step.op, ESO_OP_LL): begin
          rsv_nxt = ESO_RSV_HELD; // RULE_04
        end
        op_is(step.op, ESO_OP_SC): begin
          // Test first, then clear, in step order
          sc_done_nxt    = 1'h1; // RULE_09
          sc_success_nxt = (rsv_r == ESO_RSV_HELD) && !atomic_break; // RULE_04
          rsv_nxt        = ESO_RSV_IDLE; // RULE_04
          if (sc_success_nxt) begin
            sc_count_nxt = sc_count_r + SC_CNT_W'(1);
          end
        end
        op_is(step.op, ESO_OP_ERET): begin
          rsv_nxt = ESO_RSV_IDLE; // RULE_06
        end
        op_is(step.op, ESO_OP_NONE),
        op_is(step.op, ESO_OP_OTHER): begin
          rsv_nxt = rsv_nxt;
        end
        default: begin
          rsv_nxt = rsv_nxt;
        end
      endcase
    end
    reservation_flag_nxt = (rsv_nxt == ESO_RSV_HELD);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rsv_r              <= ESO_RSV_IDLE; // RULE_12
      reservation_flag_r <= 1'h0; // RULE_12
      sc_done_r          <= 1'h0;
      sc_success_r       <= 1'h0;
      sc_count_r         <= '0;
    end else if (ce) begin
      rsv_r              <= rsv_nxt;
      reservation_flag_r <= reservation_flag_nxt;
      sc_done_r          <= sc_done_nxt;
      sc_success_r       <= sc_success_nxt;
      sc_count_r         <= sc_count_nxt;
    end
  end

  // Result writes: own-time now, deferred ones held for the next instruction
  always_comb begin
    pend_nxt    = pend_r;
    wb_now_nxt  = '0;
    wb_late_nxt = '0;
    if (step.valid) begin
      if (step.wr_now) begin
        wb_now_nxt.valid = 1'h1; // RULE_07
        wb_now_nxt.idx   = step.now_idx;
        wb_now_nxt.data  = step.now_data;
      end
      // Previous instruction's deferred write lands with this one, unordered
      wb_late_nxt = pend_r; // RULE_08 RULE_10
      pend_nxt    = '0;
      if (step.wr_late) begin
        pend_nxt.valid = 1'h1; // RULE_08
        pend_nxt.idx   = step.late_idx;
        pend_nxt.data  = step.late_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_r    <= '0;
      wb_now_r  <= '0;
      wb_late_r <= '0;
    end else if (ce) begin
      pend_r    <= pend_nxt;
      wb_now_r  <= wb_now_nxt;
      wb_late_r <= wb_late_nxt;
    end
  end

endmodule
`default_nettype wire

/* verification/eso_checker.sv */
// Concurrent checks on the byte-order and reservation block ports
`timescale 1ns/10ps
`default_nettype none
module eso_checker
  import eso_pkg::*;
(
  input wire logic      mclk,
  input wire logic      rst,
  input wire logic      ce,
  input wire logic      memory_byte_order,
  input wire logic      user_mode,
  input wire logic      atomic_break,
  input wire eso_step_t step,
  input wire logic      avs_read,
  input wire logic      avs_write,
  input wire logic      avs_waitrequest,
  input wire logic      cpu_byte_order_r,
  input wire logic      user_order_flip_r,
  input wire logic      reservation_flag_r,
  input wire logic      sc_done_r,
  input wire logic      sc_success_r,
  input wire eso_wb_t   wb_now_r,
  input wire eso_wb_t   wb_late_r
);
  wire go = ce && step.valid;
  wire ll = go && step.op == ESO_OP_LL;
  wire sc = go && step.op == ESO_OP_SC;
  wire er = go && step.op == ESO_OP_ERET;
  // Memory order as caught on the first enabled edge after reset
  logic mem_cap_r;
  logic cap_done_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      cap_done_r <= 1'h0;
    end else if (ce && !cap_done_r) begin
      mem_cap_r  <= memory_byte_order;
      cap_done_r <= 1'h1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  flip_user_a: assert property (ce && !user_mode |=> !user_order_flip_r)
    else $error("flip outside user mode");
  order_xor_a: assert property (!$past(rst) && !$past(rst, 2) |->
    cpu_byte_order_r == (mem_cap_r ^ user_order_flip_r)) else $error("load/store order wrong");
  ll_set_a: assert property (ll |=> reservation_flag_r) else $error("linked load left flag clear");
  sc_test_a: assert property (sc |=> sc_done_r && !reservation_flag_r &&
    sc_success_r == ($past(reservation_flag_r) && !$past(atomic_break))) else $error("store result wrong");
  brk_clr_a: assert property (ce && atomic_break && !ll |=> !reservation_flag_r)
    else $error("break kept flag");
  eret_clr_a: assert property (er |=> !reservation_flag_r) else $error("return kept flag");
  rst_clr_a: assert property (disable iff (1'b0) rst |=> !reservation_flag_r && !sc_done_r)
    else $error("flag set after reset");
  now_wb_a: assert property (go && step.wr_now |=> wb_now_r.valid &&
    wb_now_r.idx == $past(step.now_idx) && wb_now_r.data == $past(step.now_data)) else $error("own write lost");
  late_wb_a: assert property (go && step.wr_late ##1 go |=> wb_late_r.valid &&
    wb_late_r.idx == $past(step.late_idx, 2)) else $error("late write lost");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing");
  cover property (sc ##1 sc_success_r);
  cover property (go && step.wr_late ##1 go);
  cover property (avs_read && !avs_waitrequest);
endmodule
bind eso_top eso_checker u_eso_checker (.*);
`default_nettype wire

/* verification/eso_gpr_mdl.sv */
// Register file model standing for the core's load/store path
`timescale 1ns/10ps
`default_nettype none
module eso_gpr_mdl
  import eso_pkg::*;
(
  input  wire logic                 mclk,
  input  wire eso_wb_t              wb_now_r,
  input  wire eso_wb_t              wb_late_r,
  input  wire logic [GPR_IDX_W-1:0] rd_idx,
  output logic [GPR_DATA_W-1:0]     rd_data
);
  logic [GPR_DATA_W-1:0] gpr [32];
  always @(posedge mclk) begin
    if (wb_late_r.valid === 1'h1) gpr[wb_late_r.idx] <= wb_late_r.data;
    if (wb_now_r.valid === 1'h1) gpr[wb_now_r.idx] <= wb_now_r.data;
  end
  assign rd_data = gpr[rd_idx];
endmodule
`default_nettype wire

/* verification/tb.sv */
// Testbench for the byte-order and reservation block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import eso_pkg::*;
  logic        mclk, rst, ce, mem, umode, brk, rd, wr, wq, cpu, flip, rsv, scd, scs;
  logic [3:0]  addr;
  logic [31:0] wdat, rdat, gdat, q;
  logic [4:0]  gidx;
  eso_step_t   stp;
  eso_wb_t     wbn, wbl;
  int          err_count, check_count;
  always #25 mclk = ~mclk;
  eso_top u_eso_top (.mclk(mclk), .rst(rst), .ce(ce), .memory_byte_order(mem), .user_mode(umode),
    .atomic_break(brk), .step(stp), .avs_read(rd), .avs_write(wr), .avs_address(addr), .avs_byteenable(4'hF),
    .avs_writedata(wdat), .avs_waitrequest(wq), .avs_readdata(rdat), .cpu_byte_order_r(cpu),
    .user_order_flip_r(flip), .reservation_flag_r(rsv), .sc_done_r(scd), .sc_success_r(scs),
    .wb_now_r(wbn), .wb_late_r(wbl));
  eso_gpr_mdl u_eso_gpr_mdl (.mclk(mclk), .wb_now_r(wbn), .wb_late_r(wbl), .rd_idx(gidx), .rd_data(gdat));
  task end_sim;
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task av(logic w, logic [3:0] a, logic [31:0] d);
    int n;
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= d;
    for (n = 0; n < 20 && wq !== 1'h0; n++) @(posedge mclk);
    if (n == 20) begin
      err_count++;
      end_sim;
    end
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task st(eso_op_t op, logic b, logic wl);
    @(posedge mclk);
    stp <= '{1'h1, op, 1'h1, 5'h03, 32'hA5A5_0003, wl, 5'h05, 32'h5A5A_0005};
    brk <= b;
  endtask
  task idle;
    @(posedge mclk);
    stp.valid <= 1'h0;
    brk <= 1'h0;
    @(negedge mclk);
  endtask
  task t_order;
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      rst <= 1'h1;
      mem <= m[0];
      repeat (6) @(posedge mclk);
      rst <= 1'h0;
      @(negedge mclk);
      chk("rsv", 32'h0, rsv);
      chk("waitreq", 32'h1, wq);
      for (int k = 0; k < 4; k++) begin
        av(1'h1, OFS_CONTROL, k);
        umode <= k[1];
        mem <= !m[0];
        repeat (3) idle;
        chk("cpu order", m[0] ^ (k[0] & k[1]), cpu);
        chk("flip", k[0] & k[1], flip);
        av(1'h0, OFS_STATUS, 32'h0);
        chk("status", {k[1], 1'h0, k[0] & k[1], m[0] ^ (k[0] & k[1]), m[0]}, q);
        av(1'h0, OFS_CONTROL, 32'h0);
        chk("control", k[0], q);
      end
    end
    av(1'h1, 4'hC, 32'hFFFF_FFFF);
    av(1'h0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask
  task t_rsv;
    st(ESO_OP_LL, 1'h0, 1'h0);
    st(ESO_OP_SC, 1'h0, 1'h0);
    idle;
    chk("sc ok", 32'h6, {scd, scs, rsv});
    st(ESO_OP_SC, 1'h0, 1'h0);
    idle;
    chk("sc again", 32'h4, {scd, scs, rsv});
    st(ESO_OP_LL, 1'h0, 1'h0);
    st(ESO_OP_OTHER, 1'h1, 1'h0);
    st(ESO_OP_SC, 1'h0, 1'h0);
    idle;
    chk("sc broken", 32'h4, {scd, scs, rsv});
    st(ESO_OP_LL, 1'h0, 1'h0);
    st(ESO_OP_ERET, 1'h0, 1'h0);
    idle;
    chk("eret", 32'h0, rsv);
    st(ESO_OP_LL, 1'h1, 1'h0);
    idle;
    chk("ll wins", 32'h1, rsv);
    st(ESO_OP_SC, 1'h1, 1'h0);
    idle;
    chk("sc with break", 32'h4, {scd, scs, rsv});
    av(1'h0, OFS_SC_COUNT, 32'h0);
    chk("sc count", 32'h1, q);
  endtask
  task t_wb;
    st(ESO_OP_NONE, 1'h0, 1'h1);
    idle;
    chk("now", {1'h1, 5'h03}, {wbn.valid, wbn.idx});
    chk("now data", 32'hA5A5_0003, wbn.data);
    chk("late early", 32'h0, wbl.valid);
    idle;
    chk("late held", 32'h0, wbl.valid);
    st(ESO_OP_OTHER, 1'h0, 1'h1);
    st(ESO_OP_NONE, 1'h0, 1'h0);
    idle;
    chk("late", {1'h1, 5'h05}, {wbl.valid, wbl.idx});
    chk("late data", 32'h5A5A_0005, wbl.data);
    @(posedge mclk);
    gidx <= 5'h05;
    @(negedge mclk);
    chk("gpr", 32'h5A5A_0005, gdat);
  endtask
  task t_ce;
    @(posedge mclk);
    ce <= 1'h0;
    st(ESO_OP_LL, 1'h0, 1'h1);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("frozen", 32'h0, {rsv, wbn.valid, wbl.valid, scd});
    @(posedge mclk);
    ce <= 1'h1;
    idle;
    chk("thawed", 32'h3, {rsv, wbn.valid});
    av(1'h0, OFS_STATUS, 32'h0);
    chk("pend status", 32'h3D, q);
  endtask
  initial begin
    {mclk, mem, umode, brk, rd, wr, addr, wdat, gidx} = '0;
    rst = 1'h1;
    ce = 1'h1;
    stp = '0;
    err_count = 0;
    check_count = 0;
    fork
      begin
        repeat (20000) @(posedge mclk);
        err_count++;
        end_sim;
      end
    join_none
    t_order;
    t_rsv;
    t_wb;
    t_ce;
    end_sim;
  end
endmodule
`default_nettype wire
